// *** hw/iat_regs.sv ***
// Interrupt enable, tone status and indirect register window
`timescale 1ns/1ps
module iat_regs #(
  parameter int UPDATE_CYCLES = iat_pkg::UPDATE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port from the serial control interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Tone detector: index 0..15 in keypad order 1-9,0,*,#,A,B,C,D
  input wire logic tone_valid,
  input wire logic [3:0] tone_key_index,
  // Calibration monitor
  input wire logic calib_error_event,
  // Masked interrupt requests
  output logic irq_calib,
  output logic irq_indirect_done,
  output logic irq_tone,
  output logic irq_any
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_status3;
  logic wr_enable3;
  logic wr_data_low;
  logic wr_data_high;
  logic wr_address;
  logic update_tick;

  assign wr_status3 = reg_wr && (reg_addr == iat_pkg::OFF_IRQ_STATUS_THREE);
  assign wr_enable3 = reg_wr && (reg_addr == iat_pkg::OFF_IRQ_ENABLE_THREE);
  assign wr_data_low = reg_wr && (reg_addr == iat_pkg::OFF_IND_DATA_LOW);
  assign wr_data_high = reg_wr && (reg_addr == iat_pkg::OFF_IND_DATA_HIGH);
  assign wr_address = reg_wr && (reg_addr == iat_pkg::OFF_IND_ADDRESS);

  // ----------------------------------------------------------------
  // Update tick
  // ----------------------------------------------------------------
  // Period is a parameter so a bench can shorten the wait
  // 16 kHz service rate
  iat_tick_div #(
    .CYCLES(UPDATE_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .nrst(nrst),
    .tick(update_tick)
  );

  // ----------------------------------------------------------------
  // Interrupt enable three
  // ----------------------------------------------------------------
  logic [2:0] irq_enable_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_enable_q <= iat_pkg::RST_IRQ_ENABLE;
    end else if (wr_enable3) begin
      irq_enable_q <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Tone status
  // ----------------------------------------------------------------
  logic digit_present_q;
  logic [3:0] key_code_q;
  logic [3:0] key_code_d;

  // digits one to nine map to their value, zero to 1010
  // symbol and letter keys follow on, D wraps to 0000
  always_comb begin
    key_code_d = tone_key_index + 4'h1;
    case (tone_key_index)
      4'h9: key_code_d = iat_pkg::KEY_ZERO;
      4'ha: key_code_d = iat_pkg::KEY_STAR;
      4'hb: key_code_d = iat_pkg::KEY_HASH;
      4'hc: key_code_d = iat_pkg::KEY_A;
      4'hd: key_code_d = iat_pkg::KEY_B;
      4'he: key_code_d = iat_pkg::KEY_C;
      4'hf: key_code_d = iat_pkg::KEY_D;
      default: key_code_d = tone_key_index + 4'h1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      digit_present_q <= 1'b0;
    end else begin
      digit_present_q <= tone_valid;
    end
  end

  // Last key is held after the tone ends so software can still read it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      key_code_q <= iat_pkg::RST_KEY_CODE;
    end else if (tone_valid) begin
      key_code_q <= key_code_d;
    end
  end

  // ----------------------------------------------------------------
  // Indirect access engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IAT_IDLE,
    IAT_READ_WAIT,
    IAT_WRITE_WAIT
  } iat_state_t;

  iat_state_t state_q;
  logic data_written_q;
  logic [7:0] target_addr_q;
  logic [15:0] data_window_q;
  logic [15:0] ind_mem_q [iat_pkg::IND_DEPTH];
  logic service;

  assign service = update_tick && (state_q != IAT_IDLE);

  // Remembers a data write so the next address write becomes a store
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      data_written_q <= 1'b0;
    end else if (wr_address) begin
      data_written_q <= 1'b0;
    end else if (wr_data_low || wr_data_high) begin
      data_written_q <= 1'b1;
    end
  end

  // pending while the state is not idle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= IAT_IDLE;
    end else begin
      case (state_q)
        IAT_IDLE: begin
          if (wr_address) begin
            state_q <= data_written_q ? IAT_WRITE_WAIT : IAT_READ_WAIT;
          end
        end
        IAT_READ_WAIT, IAT_WRITE_WAIT: begin
          // A new address written before service restarts the request
          if (wr_address) begin
            state_q <= data_written_q ? IAT_WRITE_WAIT : IAT_READ_WAIT;
          end else if (update_tick) begin
            state_q <= IAT_IDLE;
          end
        end
        default: state_q <= IAT_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      target_addr_q <= iat_pkg::RST_BYTE;
    end else if (wr_address) begin
      target_addr_q <= reg_wdata;
    end
  end

  // Host byte writes take priority over a load landing in the same cycle
  // low and high byte of the window
  // load from memory on a serviced read
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      data_window_q <= iat_pkg::RST_WORD;
    end else if (wr_data_low) begin
      data_window_q[7:0] <= reg_wdata;
    end else if (wr_data_high) begin
      data_window_q[15:8] <= reg_wdata;
    end else if (service && !wr_address && state_q == IAT_READ_WAIT) begin
      data_window_q <= ind_mem_q[target_addr_q];
    end
  end

  // Cleared on reset so a load before any store reads zero; costs a wide reset fan-out
  // store the window at the addressed location
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < iat_pkg::IND_DEPTH; i++) begin
        ind_mem_q[i] <= iat_pkg::RST_WORD;
      end
    end else if (service && !wr_address && state_q == IAT_WRITE_WAIT) begin
      ind_mem_q[target_addr_q] <= data_window_q;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status three
  // ----------------------------------------------------------------
  logic [2:0] irq_status_q;
  logic [2:0] irq_set;
  logic tone_valid_q;
  logic done_pulse;

  // No completion is reported for a tick that an address write overrides
  assign done_pulse = service && !wr_address;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tone_valid_q <= 1'b0;
    end else begin
      tone_valid_q <= tone_valid;
    end
  end

  always_comb begin
    irq_set = 3'h0;
    irq_set[iat_pkg::BIT_CALIB] = calib_error_event;
    irq_set[iat_pkg::BIT_IND_DONE] = done_pulse;
    irq_set[iat_pkg::BIT_TONE] = tone_valid && !tone_valid_q;
  end

  // write one clears, a set in the same cycle wins
  // same clearing scheme for the tone flag
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_status_q <= iat_pkg::RST_IRQ_STATUS;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_status3 ? reg_wdata[2:0] : 3'h0)) | irq_set;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------
  logic [2:0] irq_masked;

  for (genvar b = 0; b < 3; b++) begin : g_gate
    assign irq_masked[b] = irq_status_q[b] && irq_enable_q[b];
  end

  assign irq_calib = irq_masked[iat_pkg::BIT_CALIB];
  assign irq_indirect_done = irq_masked[iat_pkg::BIT_IND_DONE];
  assign irq_tone = irq_masked[iat_pkg::BIT_TONE];
  assign irq_any = |irq_masked;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;

  // reserved bits zero, unmapped offsets zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      iat_pkg::OFF_IRQ_STATUS_THREE: rdata_d = {5'h00, irq_status_q};
      iat_pkg::OFF_IRQ_ENABLE_THREE: rdata_d = {5'h00, irq_enable_q};
      iat_pkg::OFF_TONE_STATUS: rdata_d = {3'h0, digit_present_q, key_code_q};
      iat_pkg::OFF_IND_DATA_LOW: rdata_d = data_window_q[7:0];
      iat_pkg::OFF_IND_DATA_HIGH: rdata_d = data_window_q[15:8];
      iat_pkg::OFF_IND_ADDRESS: rdata_d = target_addr_q;
      iat_pkg::OFF_IND_STATUS: rdata_d = {7'h00, state_q != IAT_IDLE};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= iat_pkg::RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end
endmodule

// *** hw/iat_pkg.sv ***
// Constants and register map for the indirect access and tone status bank
package iat_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_STATUS_THREE = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE_THREE = 8'h17;
  localparam logic [7:0] OFF_TONE_STATUS = 8'h18;
  localparam logic [7:0] OFF_IND_DATA_LOW = 8'h1c;
  localparam logic [7:0] OFF_IND_DATA_HIGH = 8'h1d;
  localparam logic [7:0] OFF_IND_ADDRESS = 8'h1e;
  localparam logic [7:0] OFF_IND_STATUS = 8'h1f;

  // ----------------------------------------------------------------
  // Field positions and indirect memory size
  // ----------------------------------------------------------------
  localparam int BIT_CALIB = 2;
  localparam int BIT_IND_DONE = 1;
  localparam int BIT_TONE = 0;
  localparam int BIT_DIGIT_PRESENT = 4;
  localparam int BIT_PENDING = 0;
  localparam int IND_WIDTH = 16;
  localparam int IND_DEPTH = 256;

  // ----------------------------------------------------------------
  // Key codes reported in the tone status register
  // ----------------------------------------------------------------
  localparam logic [3:0] KEY_ZERO = 4'ha;
  localparam logic [3:0] KEY_STAR = 4'hb;
  localparam logic [3:0] KEY_HASH = 4'hc;
  localparam logic [3:0] KEY_A = 4'hd;
  localparam logic [3:0] KEY_B = 4'he;
  localparam logic [3:0] KEY_C = 4'hf;
  localparam logic [3:0] KEY_D = 4'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;
  localparam logic [2:0] RST_IRQ_STATUS = 3'h0;
  localparam logic [3:0] RST_KEY_CODE = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Update rate
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200000000;
  localparam int UPDATE_RATE_HZ = 16000;
  localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_RATE_HZ;
  localparam int UPDATE_CNT_W = 14;
endpackage

// *** hw/iat_tick_div.sv ***
// Divider that makes the internal indirect update enable pulse
`timescale 1ns/1ps
module iat_tick_div #(
  parameter int CYCLES = iat_pkg::UPDATE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Enable pulse, one cycle every CYCLES clocks
  output logic tick
);
  localparam logic [iat_pkg::UPDATE_CNT_W-1:0] LAST = iat_pkg::UPDATE_CNT_W'(CYCLES - 1);

  logic [iat_pkg::UPDATE_CNT_W-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Registered so the pulse is clean even when CYCLES is 1
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
    end
  end
endmodule

// *** tb/iat_regs_chk.sv ***
// Concurrent checks on the register port and interrupt outputs
`timescale 1ns/1ps
module iat_regs_chk #(
  parameter int UPDATE_CYCLES = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Detector inputs
  input wire logic tone_valid,
  input wire logic [3:0] tone_key_index,
  input wire logic calib_error_event,
  // Interrupts
  input wire logic irq_calib,
  input wire logic irq_indirect_done,
  input wire logic irq_tone,
  input wire logic irq_any
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_en_wr;
    reg_wr && reg_addr == iat_pkg::OFF_IRQ_ENABLE_THREE;
  endsequence
  sequence s_addr_wr;
    reg_wr && reg_addr == iat_pkg::OFF_IND_ADDRESS;
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == iat_pkg::OFF_IND_STATUS;
  endsequence
  sequence s_tone_rd;
    reg_rd && reg_addr == iat_pkg::OFF_TONE_STATUS;
  endsequence
  a_irq_any_or: assert property (irq_any == (irq_calib | irq_indirect_done | irq_tone))
    else $error("irq_any differs from OR of sources");
  a_calib_mask: assert property (s_en_wr ##0 !reg_wdata[2] |=> !irq_calib)
    else $error("calibration irq not masked");
  a_done_mask: assert property (s_en_wr ##0 !reg_wdata[1] |=> !irq_indirect_done)
    else $error("indirect done irq not masked");
  a_tone_mask: assert property (s_en_wr ##0 !reg_wdata[0] |=> !irq_tone)
    else $error("tone irq not masked");
  a_present_follows: assert property (s_tone_rd |=> reg_rdata[4] == $past(tone_valid, 2))
    else $error("digit present bit wrong");
  a_pending_set: assert property (s_addr_wr ##1 s_stat_rd |=> reg_rdata[0])
    else $error("pending not set after address write");
  a_tone_resv: assert property (s_tone_rd |=> reg_rdata[7:5] == 3'h0)
    else $error("tone status reserved bits set");
  a_status_resv: assert property (s_stat_rd |=> reg_rdata[7:1] == 7'h00)
    else $error("indirect status reserved bits set");
  a_enable_resv: assert property (reg_rd && reg_addr == iat_pkg::OFF_IRQ_ENABLE_THREE |=> reg_rdata[7:3] == 5'h00)
    else $error("enable reserved bits set");
endmodule

bind iat_regs iat_regs_chk #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tone_valid(tone_valid),
  .tone_key_index(tone_key_index), .calib_error_event(calib_error_event), .irq_calib(irq_calib),
  .irq_indirect_done(irq_indirect_done), .irq_tone(irq_tone), .irq_any(irq_any));

// *** tb/iat_host.sv ***
// Host processor model issuing register reads and writes
`timescale 1ns/1ps
module iat_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    // Return once the write has settled so callers can look at outputs
    #1;
  endtask
  // Write then read on the very next edge, as the port allows back to back
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] dw, input logic [7:0] ra, output logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dw;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ra;
    reg_wdata <= ~dw;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~ra;
    #1 d = reg_rdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

// *** tb/indirect_access_and_tone_status_tb_top.sv ***
// Self-checking bench for the indirect access and tone status bank
`timescale 1ns/1ps
module indirect_access_and_tone_status_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic tone_valid = 1'b0;
  logic [3:0] tone_key_index = 4'h0;
  logic calib_error_event = 1'b0;
  logic reg_wr, reg_rd, irq_calib, irq_indirect_done, irq_tone, irq_any;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  localparam int UPD = 8;
  always #2.5 mclk = ~mclk;
  // Edges since reset release; the update tick is serviced when this becomes one past a multiple of UPD
  always @(posedge mclk) cyc <= nrst ? cyc + 1 : 0;
  iat_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  // Short update period keeps the indirect waits to a few cycles
  iat_regs #(.UPDATE_CYCLES(UPD)) dut (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tone_valid(tone_valid),
    .tone_key_index(tone_key_index), .calib_error_event(calib_error_event), .irq_calib(irq_calib),
    .irq_indirect_done(irq_indirect_done), .irq_tone(irq_tone), .irq_any(irq_any));
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string name);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    host.rd(a, d);
    chk(d, exp, name);
  endtask
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // poll pending, five polls cover one full update period
  task automatic wait_idle;
    for (int n = 0; n < 5; n++) begin
      host.rd(iat_pkg::OFF_IND_STATUS, d);
      if (d[0] === 1'b0) break;
    end
    chk({7'h00, d[0]}, 8'h00, "pending cleared");
  endtask
  // key codes in keypad order 1-9, 0, *, #, A-D
  function automatic logic [3:0] key_of(input logic [3:0] idx);
    case (idx)
      4'h9: key_of = iat_pkg::KEY_ZERO;
      4'ha: key_of = iat_pkg::KEY_STAR;
      4'hb: key_of = iat_pkg::KEY_HASH;
      4'hc: key_of = iat_pkg::KEY_A;
      4'hd: key_of = iat_pkg::KEY_B;
      4'he: key_of = iat_pkg::KEY_C;
      4'hf: key_of = iat_pkg::KEY_D;
      default: key_of = idx + 4'h1;
    endcase
  endfunction
  // Stop on the edge whose next-but-one edge lies two cycles after an update tick
  task automatic align_tick;
    @(posedge mclk);
    while (cyc % UPD != UPD - 1) @(posedge mclk);
  endtask
  task automatic pulse(input logic [3:0] k);
    @(posedge mclk);
    tone_key_index <= k;
    tone_valid <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_reserved;
    rdchk(8'h17, 8'h00, "enable reset");
    rdchk(8'h18, 8'h00, "tone reset");
    rdchk(8'h1c, 8'h00, "data low reset");
    rdchk(8'h1f, 8'h00, "status reset");
    host.wr(8'h17, 8'hff);
    rdchk(8'h17, 8'h07, "enable readback");
    host.wr(8'h18, 8'hff);
    rdchk(8'h18, 8'h00, "tone status read only");
    host.wr(8'h1f, 8'hff);
    rdchk(8'h1f, 8'h00, "indirect status read only");
    rdchk(8'h00, 8'h00, "unmapped");
  endtask
  task automatic t_tone;
    host.wr(8'h17, 8'h00);
    pulse(4'h4);
    chk({7'h00, irq_tone}, 8'h00, "tone masked");
    host.wr(8'h17, 8'h01);
    chk({7'h00, irq_tone}, 8'h01, "tone enabled");
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      tone_valid <= 1'b0;
      host.wr(8'h14, 8'h01);
      chk({7'h00, irq_tone}, 8'h00, "tone cleared");
      pulse(i[3:0]);
      chk({7'h00, irq_tone}, 8'h01, "tone flag");
      rdchk(8'h18, {4'h1, key_of(i[3:0])}, "key code");
    end
    @(posedge mclk);
    tone_valid <= 1'b0;
    rdchk(8'h18, 8'h00, "present low, key D held");
    host.wr(8'h14, 8'h01);
  endtask
  task automatic t_calib;
    host.wr(8'h17, 8'h04);
    @(posedge mclk);
    calib_error_event <= 1'b1;
    @(posedge mclk);
    calib_error_event <= 1'b0;
    #1 chk({6'h00, irq_calib, irq_any}, 8'h03, "calib irq");
    host.wr(8'h17, 8'h00);
    chk({7'h00, irq_calib}, 8'h00, "calib masked");
    host.wr(8'h14, 8'h04);
    host.wr(8'h17, 8'h04);
    chk({7'h00, irq_calib}, 8'h00, "calib cleared");
  endtask
  task automatic t_indirect;
    host.wr(8'h17, 8'h02);
    host.wr(8'h1c, 8'h34);
    host.wr(8'h1d, 8'h12);
    align_tick();
    host.wr_rd(8'h1e, 8'h05, 8'h1f, d);
    chk(d, 8'h01, "pending set");
    repeat (UPD - 3) @(posedge mclk);
    #1 chk({7'h00, irq_indirect_done}, 8'h00, "done not early");
    @(posedge mclk);
    #1 chk({7'h00, irq_indirect_done}, 8'h01, "done on tick");
    wait_idle();
    chk({7'h00, irq_indirect_done}, 8'h01, "done flag");
    host.wr(8'h14, 8'h02);
    chk({7'h00, irq_indirect_done}, 8'h00, "done cleared");
    host.wr(8'h1e, 8'h06);
    wait_idle();
    rdchk(8'h1c, 8'h00, "load other location");
    host.wr(8'h17, 8'h00);
    chk({7'h00, irq_indirect_done}, 8'h00, "done masked");
    host.wr(8'h1e, 8'h05);
    wait_idle();
    rdchk(8'h1c, 8'h34, "load low");
    rdchk(8'h1d, 8'h12, "load high");
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset_and_reserved();
    t_tone();
    t_calib();
    t_indirect();
    final_report();
  end
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule
